/* File: rtl/fir_eq_pkg.sv */
// Shared constants for the equaliser coefficient taps, register map and sample path.
package fir_eq_pkg;
   // ----------------------------------------------------------------
   // Bus and datapath widths
   // ----------------------------------------------------------------
   localparam int ADDR_W = 14;
   localparam int DATA_W = 32;
   localparam int IDX_W = 12;
   localparam int SAMPLE_W = 12;
   localparam int OUT_W = 16;
   localparam int SIDE_W = 12;
   localparam int CENTER_W = 18;
   localparam int PROD_W = 36;
   localparam int ACC_W = 40;
   localparam int NUM_TAPS = 9;
   localparam int CENTER_TAP = 4;
   localparam int FRAC_BITS = 16;
   localparam int FIFO_DEPTH = 16;
   localparam int FIFO_CNT_W = 5;

   // ----------------------------------------------------------------
   // Register indices, byte address is four times the index
   // ----------------------------------------------------------------
   localparam logic [IDX_W-1:0] IDX_TAP4 = 12'h41E;
   localparam logic [IDX_W-1:0] IDX_CENTER = 12'h420;
   localparam logic [IDX_W-1:0] IDX_TAP6 = 12'h423;
   localparam logic [IDX_W-1:0] IDX_TAP7 = 12'h425;
   localparam logic [IDX_W-1:0] IDX_TAP8 = 12'h427;
   localparam logic [IDX_W-1:0] IDX_CFG = 12'h430;
   localparam logic [IDX_W-1:0] IDX_STATUS = 12'h431;

   // ----------------------------------------------------------------
   // Register widths, reset values and fields
   // ----------------------------------------------------------------
   localparam int SIDE_REG_W = 16;
   localparam int CENTER_REG_W = 24;
   localparam int CFG_W = 6;
   localparam logic [SIDE_REG_W-1:0] SIDE_RESET = 16'h0000;
   localparam logic [CENTER_REG_W-1:0] CENTER_RESET = 24'h00_0000;
   localparam logic [CFG_W-1:0] CFG_RESET = 6'h00;
   localparam int MODE_LSB = 0;
   localparam int MODE_W = 2;
   localparam int SCW_LSB = 2;
   localparam int SCW_W = 3;
   localparam int MERGE_BIT = 5;
   localparam logic [SCW_W-1:0] SCW_MAX = 3'h6;
   localparam logic [MODE_W-1:0] MODE_BYPASS = 2'h0;
   localparam logic [MODE_W-1:0] MODE_ENABLE = 2'h2;
   localparam int STAT_LEVEL_LSB = 0;
   localparam int STAT_LINK_BIT = 8;
   localparam int STAT_ACTIVE_BIT = 9;

   // ----------------------------------------------------------------
   // Bus answers
   // ----------------------------------------------------------------
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : fir_eq_pkg

/* File: rtl/sample_fifo.sv */
// Synchronous FIFO with registered full, empty and level flags.
`timescale 1ns/100ps
`default_nettype none
module sample_fifo #(
   parameter int WIDTH = 12,
   parameter int DEPTH = 16,
   parameter int CNT_W = 5
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Fill side
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   // Drain side
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready,
   // Level
   output logic [CNT_W-1:0] level
);
   localparam int PTR_W = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PTR_W-1:0] wr_ptr_q;
   logic [PTR_W-1:0] rd_ptr_q;
   logic [CNT_W-1:0] count_q;
   logic [CNT_W-1:0] count_d;
   logic in_ready_q;
   logic out_valid_q;
   logic push;
   logic pop;

   assign push = in_valid && in_ready_q;
   assign pop = out_valid_q && out_ready;
   assign count_d = count_q + CNT_W'(push) - CNT_W'(pop);

   always_ff @(posedge aclk) begin
      if (push) begin
         mem[wr_ptr_q] <= in_data;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q <= '0;
         in_ready_q <= 1'b0;
         out_valid_q <= 1'b0;
      end else begin
         if (push) begin
            wr_ptr_q <= PTR_W'((32'(wr_ptr_q) + 1) % DEPTH);
         end
         if (pop) begin
            rd_ptr_q <= PTR_W'((32'(rd_ptr_q) + 1) % DEPTH);
         end
         count_q <= count_d;
         // Flags come from the next level so a full FIFO stalls the source at once.
         in_ready_q <= (32'(count_d) != DEPTH);
         out_valid_q <= (count_d != '0);
      end
   end

   assign in_ready = in_ready_q;
   assign out_valid = out_valid_q;
   assign out_data = mem[rd_ptr_q];
   assign level = count_q;
endmodule : sample_fifo
`default_nettype wire

/* File: rtl/tap_product.sv */
// One tap multiplier with side-weight scaling for non-centre taps.
`timescale 1ns/100ps
`default_nettype none
module tap_product (
   // Operands
   input wire logic signed [fir_eq_pkg::SAMPLE_W-1:0] sample,
   input wire logic signed [fir_eq_pkg::CENTER_W-1:0] coeff,
   input wire logic is_center,
   input wire logic [fir_eq_pkg::SCW_W-1:0] weight,
   // Result, LSB weight 2^-16
   output logic signed [fir_eq_pkg::PROD_W-1:0] product
);
   logic signed [fir_eq_pkg::SAMPLE_W+fir_eq_pkg::CENTER_W-1:0] raw;

   assign raw = sample * coeff;

   always_comb begin
      if (is_center) begin
         product = fir_eq_pkg::PROD_W'(raw);
      end else begin
         product = fir_eq_pkg::PROD_W'(raw) <<< weight; // see [R10]
      end
   end
endmodule : tap_product
`default_nettype wire

/* File: rtl/fir_equalizer_coeff_taps.sv */
// Equaliser coefficient registers, AXI4-Lite slave and 9-tap filter datapath.
//
// Functional notes
// [R1] Non-centre coefficients are 12-bit signed values in bits 11:0.
// [R2] Centre fifth tap is 18-bit signed in bits 17:0 of 24-bit register.
// [R3] Dual-channel: channel A set drives channel A filter, one register per tap.
// [R4] Single-channel: same set at same positions drives the merged filter.
// [R5] Consecutive registers map to taps four, five, six, seven (and eight).
// [R6] Coefficient registers reset to zero; centre at 0x420, then 0x423, 0x425, 0x427.
// [R7] Enabled output is the sum of nine newest samples times their coefficients.
// [R8] Mode 0 bypasses, mode 2 enables; 1 and 3 are reserved.
// [R9] Merge bit makes both filters one logical filter; set it single-channel.
// [R10] Side weight 0..6 gives non-centre LSB weight of 2^(weight-16).
// [R11] Software changes coefficients and settings only with link enable cleared.
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module fir_equalizer_coeff_taps (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address
   input wire logic [fir_eq_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [fir_eq_pkg::DATA_W-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [fir_eq_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [fir_eq_pkg::DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Sample stream in
   input wire logic [fir_eq_pkg::SAMPLE_W-1:0] in_sample,
   input wire logic in_valid,
   output logic in_ready,
   // Filtered stream out
   output logic [fir_eq_pkg::OUT_W-1:0] out_sample,
   output logic out_valid,
   input wire logic out_ready,
   // Coefficients of the taps held elsewhere
   input wire logic [fir_eq_pkg::SIDE_W-1:0] tap1_coeff,
   input wire logic [fir_eq_pkg::SIDE_W-1:0] tap2_coeff,
   input wire logic [fir_eq_pkg::SIDE_W-1:0] tap3_coeff,
   input wire logic [fir_eq_pkg::SIDE_W-1:0] tap9_coeff,
   // Filter settings shared with the rest of the filter
   input wire logic serial_link_enable,
   output logic [fir_eq_pkg::MODE_W-1:0] filter_mode_select,
   output logic filter_merge_bit,
   output logic [fir_eq_pkg::SCW_W-1:0] side_coeff_weight
);
   // ----------------------------------------------------------------
   // Types and helpers
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      WR_COLLECT = 2'b01,
      WR_RESP = 2'b10
   } wr_state_t;
   typedef enum logic [1:0] {
      RD_IDLE = 2'b01,
      RD_DATA = 2'b10
   } rd_state_t;

   function automatic logic hit(input logic [fir_eq_pkg::ADDR_W-1:0] addr,
                                input logic [fir_eq_pkg::IDX_W-1:0] idx);
      return (addr[1:0] == 2'b00) && (addr[fir_eq_pkg::ADDR_W-1:2] == idx);
   endfunction : hit
   function automatic logic [31:0] merge_strb(input logic [31:0] old,
                                             input logic [31:0] wdata,
                                             input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[8*i+:8] = wdata[8*i+:8];
         end
      end
      return res;
   endfunction : merge_strb

   // ----------------------------------------------------------------
   // Register state
   // ----------------------------------------------------------------
   logic [fir_eq_pkg::SIDE_REG_W-1:0] tap4_coeff_chan_a_q;
   logic [fir_eq_pkg::CENTER_REG_W-1:0] center_tap_coeff_q;
   logic [fir_eq_pkg::SIDE_REG_W-1:0] tap6_coeff_chan_a_q;
   logic [fir_eq_pkg::SIDE_REG_W-1:0] tap7_coeff_chan_a_q;
   logic [fir_eq_pkg::SIDE_REG_W-1:0] tap8_coeff_chan_a_q;
   logic [fir_eq_pkg::CFG_W-1:0] cfg_q;

   // ----------------------------------------------------------------
   // Write channel
   // ----------------------------------------------------------------
   wr_state_t wr_state_q;
   logic aw_have_q;
   logic w_have_q;
   logic [fir_eq_pkg::ADDR_W-1:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic aw_take;
   logic w_take;
   logic do_write;
   logic wr_mapped;
   assign aw_take = s_axi_awvalid && s_axi_awready;
   assign w_take = s_axi_wvalid && s_axi_wready;
   assign do_write = aw_have_q && w_have_q && (wr_state_q == WR_COLLECT);
   assign wr_mapped = hit(aw_addr_q, fir_eq_pkg::IDX_TAP4) ||
                      hit(aw_addr_q, fir_eq_pkg::IDX_CENTER) ||
                      hit(aw_addr_q, fir_eq_pkg::IDX_TAP6) ||
                      hit(aw_addr_q, fir_eq_pkg::IDX_TAP7) ||
                      hit(aw_addr_q, fir_eq_pkg::IDX_TAP8) ||
                      hit(aw_addr_q, fir_eq_pkg::IDX_CFG) ||
                      hit(aw_addr_q, fir_eq_pkg::IDX_STATUS);
   // Address and data are held independently so either may arrive first.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         aw_addr_q <= '0;
         w_data_q <= '0;
         w_strb_q <= '0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
      end else begin
         if (aw_take) begin
            aw_have_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end else if (do_write) begin
            aw_have_q <= 1'b0;
         end
         if (w_take) begin
            w_have_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end else if (do_write) begin
            w_have_q <= 1'b0;
         end
         s_axi_awready <= (wr_state_q == WR_COLLECT) && !aw_have_q && !aw_take;
         s_axi_wready <= (wr_state_q == WR_COLLECT) && !w_have_q && !w_take;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_state_q <= WR_COLLECT;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= fir_eq_pkg::RESP_OKAY;
      end else begin
         case (wr_state_q)
            WR_COLLECT: begin
               if (do_write) begin
                  s_axi_bvalid <= 1'b1;
                  s_axi_bresp <= wr_mapped ? fir_eq_pkg::RESP_OKAY : fir_eq_pkg::RESP_SLVERR;
                  wr_state_q <= WR_RESP;
               end
            end
            WR_RESP: begin
               if (s_axi_bready) begin
                  s_axi_bvalid <= 1'b0;
                  wr_state_q <= WR_COLLECT;
               end
            end
            default: begin
               s_axi_bvalid <= 1'b0;
               wr_state_q <= WR_COLLECT;
            end
         endcase
      end
   end
   // ----------------------------------------------------------------
   // Coefficient and settings registers
   // ----------------------------------------------------------------
   // Reserved bits are kept as written; only the coefficient fields reach the taps.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tap4_coeff_chan_a_q <= fir_eq_pkg::SIDE_RESET; // see [R6]
         center_tap_coeff_q <= fir_eq_pkg::CENTER_RESET; // see [R6]
         tap6_coeff_chan_a_q <= fir_eq_pkg::SIDE_RESET; // see [R6]
         tap7_coeff_chan_a_q <= fir_eq_pkg::SIDE_RESET; // see [R6]
         tap8_coeff_chan_a_q <= fir_eq_pkg::SIDE_RESET; // see [R6]
      end else if (do_write) begin
         if (hit(aw_addr_q, fir_eq_pkg::IDX_TAP4)) begin
            tap4_coeff_chan_a_q <= 16'(merge_strb(32'(tap4_coeff_chan_a_q), w_data_q, w_strb_q));
         end
         if (hit(aw_addr_q, fir_eq_pkg::IDX_CENTER)) begin // see [R6]
            center_tap_coeff_q <= 24'(merge_strb(32'(center_tap_coeff_q), w_data_q, w_strb_q));
         end
         if (hit(aw_addr_q, fir_eq_pkg::IDX_TAP6)) begin
            tap6_coeff_chan_a_q <= 16'(merge_strb(32'(tap6_coeff_chan_a_q), w_data_q, w_strb_q));
         end
         if (hit(aw_addr_q, fir_eq_pkg::IDX_TAP7)) begin
            tap7_coeff_chan_a_q <= 16'(merge_strb(32'(tap7_coeff_chan_a_q), w_data_q, w_strb_q));
         end
         if (hit(aw_addr_q, fir_eq_pkg::IDX_TAP8)) begin
            tap8_coeff_chan_a_q <= 16'(merge_strb(32'(tap8_coeff_chan_a_q), w_data_q, w_strb_q));
         end
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfg_q <= fir_eq_pkg::CFG_RESET;
      end else if (do_write && hit(aw_addr_q, fir_eq_pkg::IDX_CFG)) begin
         cfg_q <= 6'(merge_strb(32'(cfg_q), w_data_q, w_strb_q)); // see [R8]
      end
   end
   assign filter_mode_select = cfg_q[fir_eq_pkg::MODE_LSB+:fir_eq_pkg::MODE_W]; // see [R8]
   assign filter_merge_bit = cfg_q[fir_eq_pkg::MERGE_BIT]; // see [R9]
   assign side_coeff_weight = cfg_q[fir_eq_pkg::SCW_LSB+:fir_eq_pkg::SCW_W]; // see [R10]
   // ----------------------------------------------------------------
   // Read channel
   // ----------------------------------------------------------------
   rd_state_t rd_state_q;
   logic ar_take;
   logic [fir_eq_pkg::FIFO_CNT_W-1:0] fifo_level;
   logic filter_active;
   logic [31:0] status_word;
   assign ar_take = s_axi_arvalid && s_axi_arready;
   assign status_word = (32'(fifo_level) << fir_eq_pkg::STAT_LEVEL_LSB) |
                        (32'(serial_link_enable) << fir_eq_pkg::STAT_LINK_BIT) |
                        (32'(filter_active) << fir_eq_pkg::STAT_ACTIVE_BIT);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_state_q <= RD_IDLE;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= fir_eq_pkg::RESP_OKAY;
      end else begin
         case (rd_state_q)
            RD_IDLE: begin
               s_axi_arready <= !ar_take;
               if (ar_take) begin
                  s_axi_rvalid <= 1'b1;
                  rd_state_q <= RD_DATA;
                  s_axi_rdata <= '0;
                  s_axi_rresp <= fir_eq_pkg::RESP_SLVERR;
                  if (s_axi_araddr[1:0] == 2'b00) begin
                     s_axi_rresp <= fir_eq_pkg::RESP_OKAY;
                     case (s_axi_araddr[fir_eq_pkg::ADDR_W-1:2])
                        fir_eq_pkg::IDX_TAP4: s_axi_rdata <= 32'(tap4_coeff_chan_a_q);
                        fir_eq_pkg::IDX_CENTER: s_axi_rdata <= 32'(center_tap_coeff_q);
                        fir_eq_pkg::IDX_TAP6: s_axi_rdata <= 32'(tap6_coeff_chan_a_q);
                        fir_eq_pkg::IDX_TAP7: s_axi_rdata <= 32'(tap7_coeff_chan_a_q);
                        fir_eq_pkg::IDX_TAP8: s_axi_rdata <= 32'(tap8_coeff_chan_a_q);
                        fir_eq_pkg::IDX_CFG: s_axi_rdata <= 32'(cfg_q);
                        fir_eq_pkg::IDX_STATUS: s_axi_rdata <= status_word;
                        default: s_axi_rresp <= fir_eq_pkg::RESP_SLVERR;
                     endcase
                  end
               end
            end
            RD_DATA: begin
               s_axi_arready <= 1'b0;
               if (s_axi_rready) begin
                  s_axi_rvalid <= 1'b0;
                  rd_state_q <= RD_IDLE;
               end
            end
            default: begin
               s_axi_arready <= 1'b0;
               s_axi_rvalid <= 1'b0;
               rd_state_q <= RD_IDLE;
            end
         endcase
      end
   end
   // ----------------------------------------------------------------
   // Sample buffer
   // ----------------------------------------------------------------
   logic [fir_eq_pkg::SAMPLE_W-1:0] f_data;
   logic f_valid;
   logic f_ready;
   logic take;
   assign f_ready = !out_valid || out_ready;
   assign take = f_valid && f_ready;
   sample_fifo #(.WIDTH(fir_eq_pkg::SAMPLE_W), .DEPTH(fir_eq_pkg::FIFO_DEPTH),
      .CNT_W(fir_eq_pkg::FIFO_CNT_W)) sample_fifo_i (
      .aclk(aclk), .aresetn(aresetn), .in_data(in_sample), .in_valid(in_valid),
      .in_ready(in_ready), .out_data(f_data), .out_valid(f_valid), .out_ready(f_ready),
      .level(fifo_level)
   );
   // ----------------------------------------------------------------
   // Tap mapping and filter datapath
   // ----------------------------------------------------------------
   // One coefficient set serves both dual-channel A and the merged single
   // stream, so the tap mapping does not depend on the channel mode.
   logic signed [fir_eq_pkg::CENTER_W-1:0] coeff [fir_eq_pkg::NUM_TAPS];
   logic signed [fir_eq_pkg::SAMPLE_W-1:0] line_q [fir_eq_pkg::NUM_TAPS];
   logic signed [fir_eq_pkg::SAMPLE_W-1:0] line_d [fir_eq_pkg::NUM_TAPS];
   logic signed [fir_eq_pkg::PROD_W-1:0] prod [fir_eq_pkg::NUM_TAPS];
   logic [fir_eq_pkg::SCW_W-1:0] weight_eff;
   logic signed [fir_eq_pkg::ACC_W-1:0] acc;
   logic signed [fir_eq_pkg::ACC_W-1:0] scaled;
   logic [fir_eq_pkg::OUT_W-1:0] filt_out;
   assign coeff[0] = 18'(signed'(tap1_coeff));
   assign coeff[1] = 18'(signed'(tap2_coeff));
   assign coeff[2] = 18'(signed'(tap3_coeff));
   assign coeff[3] = 18'(signed'(tap4_coeff_chan_a_q[11:0])); // see [R1] [R3] [R4] [R5]
   assign coeff[4] = signed'(center_tap_coeff_q[17:0]); // see [R2] [R5]
   assign coeff[5] = 18'(signed'(tap6_coeff_chan_a_q[11:0])); // see [R1] [R5]
   assign coeff[6] = 18'(signed'(tap7_coeff_chan_a_q[11:0])); // see [R1] [R5]
   assign coeff[7] = 18'(signed'(tap8_coeff_chan_a_q[11:0])); // see [R1] [R5]
   assign coeff[8] = 18'(signed'(tap9_coeff));
   // Weight 7 is outside the programmable range and is held at 6.
   assign weight_eff = (side_coeff_weight > fir_eq_pkg::SCW_MAX) ? fir_eq_pkg::SCW_MAX
                                                                 : side_coeff_weight;
   assign line_d[0] = signed'(f_data);
   assign filter_active = (filter_mode_select == fir_eq_pkg::MODE_ENABLE); // see [R8]
   for (genvar i = 0; i < fir_eq_pkg::NUM_TAPS; i++) begin : g_tap
      if (i > 0) begin : g_shift
         assign line_d[i] = line_q[i-1];
      end
      tap_product tap_product_i (
         .sample(line_d[i]),
         .coeff(coeff[i]),
         .is_center(i == fir_eq_pkg::CENTER_TAP),
         .weight(weight_eff),
         .product(prod[i])
      );
   end
   always_comb begin
      acc = '0;
      for (int i = 0; i < fir_eq_pkg::NUM_TAPS; i++) begin
         acc = acc + fir_eq_pkg::ACC_W'(prod[i]); // see [R7]
      end
      scaled = acc >>> fir_eq_pkg::FRAC_BITS;
      if (scaled > 40'sd32767) begin
         filt_out = 16'h7FFF;
      end else if (scaled < -40'sd32768) begin
         filt_out = 16'h8000;
      end else begin
         filt_out = scaled[fir_eq_pkg::OUT_W-1:0];
      end
   end
   // The delay line keeps running in bypass so enabling starts with history.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < fir_eq_pkg::NUM_TAPS; i++) begin
            line_q[i] <= '0;
         end
      end else if (take) begin
         for (int i = 0; i < fir_eq_pkg::NUM_TAPS; i++) begin
            line_q[i] <= line_d[i];
         end
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         out_valid <= 1'b0;
         out_sample <= '0;
      end else if (take) begin
         out_valid <= 1'b1;
         if (filter_active) begin
            out_sample <= filt_out; // see [R7]
         end else begin
            out_sample <= 16'(signed'(f_data)); // see [R8]
         end
      end else if (out_ready) begin
         out_valid <= 1'b0;
      end
   end
endmodule : fir_equalizer_coeff_taps
`default_nettype wire

/* File: test/sample_sink.sv */
// Downstream sample sink that can stall the filtered stream.
`timescale 1ns/100ps
`default_nettype none
module sample_sink (
   input wire logic aclk,
   input wire logic stall,
   output logic out_ready
);
   // Registered, so a stall lands one cycle late as in a real sink.
   always_ff @(posedge aclk) out_ready <= !stall;
endmodule : sample_sink
`default_nettype wire

/* File: test/fir_eq_checker.sv */
// Port assertions for the equaliser taps block.
`timescale 1ns/100ps
`default_nettype none
module fir_eq_checker (
   input wire logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
   input wire logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid,
   input wire logic s_axi_rready, out_valid, out_ready, filter_merge_bit,
   input wire logic [1:0] s_axi_bresp, filter_mode_select,
   input wire logic [2:0] side_coeff_weight,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [15:0] out_sample
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
      && $stable(s_axi_bresp)) else $error("write answer dropped early");
   a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
      && $stable(s_axi_rdata)) else $error("read answer dropped early");
   a_aw_refuse: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
      else $error("write address taken twice");
   a_ar_refuse: assert property (s_axi_arvalid && s_axi_arready |=> !s_axi_arready)
      else $error("read address taken twice");
   a_b_latency: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
   a_r_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_out_hold: assert property (out_valid && !out_ready |=> out_valid
      && $stable(out_sample)) else $error("filtered sample dropped");
   a_reset_zero: assert property ($rose(aresetn) |-> filter_mode_select == 2'h0
      && !filter_merge_bit && side_coeff_weight == 3'h0) else $error("settings not cleared");
endmodule : fir_eq_checker
bind fir_equalizer_coeff_taps fir_eq_checker fir_eq_checker_i (.*);
`default_nettype wire

/* File: test/fir_equalizer_coeff_taps_tb.sv */
// Self-checking bench for the equaliser taps block.
`timescale 1ns/100ps
`default_nettype none
module fir_equalizer_coeff_taps_tb;
   logic aclk = 0, aresetn = 0, awv = 0, wv = 0, brd = 0, arv = 0, rrd = 0, ivl = 0;
   logic stall = 0, link = 0, awr, wrd, bv, arr, rv, ird, ovl, ordy, merge;
   logic [13:0] awa = 0, ara = 0;
   logic [31:0] wd = 0, rdata;
   logic [11:0] isamp = 0, far_tap = 0;
   logic [15:0] osamp, got[$];
   logic [1:0] bresp, rresp, mode;
   logic [2:0] weight;
   logic [3:0] strb = 4'hF;
   int fails = 0, checks_done = 0;
   fir_equalizer_coeff_taps fir_equalizer_coeff_taps_i (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awa), .s_axi_awprot(3'h0), .s_axi_awvalid(awv), .s_axi_awready(awr),
      .s_axi_wdata(wd), .s_axi_wstrb(strb), .s_axi_wvalid(wv), .s_axi_wready(wrd),
      .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(brd), .s_axi_araddr(ara),
      .s_axi_arprot(3'h0), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rrd), .in_sample(isamp),
      .in_valid(ivl), .in_ready(ird), .out_sample(osamp), .out_valid(ovl), .out_ready(ordy),
      .tap1_coeff(far_tap), .tap2_coeff(far_tap), .tap3_coeff(far_tap), .tap9_coeff(far_tap),
      .serial_link_enable(link), .filter_mode_select(mode), .filter_merge_bit(merge),
      .side_coeff_weight(weight));
   sample_sink sample_sink_i (.aclk(aclk), .stall(stall), .out_ready(ordy));
   initial forever #5 aclk = ~aclk;
   always @(posedge aclk) if (ovl && ordy) got.push_back(osamp);
   task automatic test_done();
      $display("checks %0d, mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : test_done
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         fails++;
         $display("unexpected at %0t: got %h, expected %h", $time, g, e);
      end
   endtask : chk
   task automatic tmo(input bit hit);
      if (hit) begin
         fails++;
         test_done();
      end
   endtask : tmo
   task automatic wr(input logic [11:0] i, input logic [31:0] d,
                     input logic [1:0] r = fir_eq_pkg::RESP_OKAY);
      int n;
      @(posedge aclk);
      {awa, wd, awv, wv, brd} <= {i, 2'b00, d, 3'b111};
      for (n = 0; n < 99 && !bv; n++) begin
         @(posedge aclk);
         if (awr) awv <= 0;
         if (wrd) wv <= 0;
      end
      brd <= 0;
      tmo(n == 99);
      chk(bresp, r);
   endtask : wr
   task automatic rd(input logic [11:0] i, input logic [31:0] d,
                     input logic [1:0] r = fir_eq_pkg::RESP_OKAY);
      int n;
      @(posedge aclk);
      {ara, arv, rrd} <= {i, 2'b00, 2'b11};
      for (n = 0; n < 99 && !rv; n++) begin
         @(posedge aclk);
         if (arr) arv <= 0;
      end
      rrd <= 0;
      tmo(n == 99);
      chk(rdata, d);
      chk(rresp, r);
   endtask : rd
   task automatic push(input int n, input logic [11:0] s, input logic [11:0] inc);
      int k, t;
      @(posedge aclk);
      k = 0;
      ivl <= 1'b1;
      isamp <= s;
      for (t = 0; t < 300 && k < n; t++) begin
         @(posedge aclk);
         if (ird) isamp <= s + 12'(++k) * inc;
      end
      ivl <= 0;
      tmo(k < n);
   endtask : push
   task automatic drain(input int n);
      for (int t = 0; t < 300 && got.size() < n; t++) @(posedge aclk);
      tmo(got.size() != n);
   endtask : drain
   task automatic reset_values();
      logic [11:0] idx[6] = '{12'h41E, 12'h420, 12'h423, 12'h425, 12'h427, 12'h430};
      foreach (idx[j]) rd(idx[j], 32'h0000_0000);
   endtask : reset_values
   task automatic field_widths();
      wr(fir_eq_pkg::IDX_TAP6, 32'hFFFF_FFFF);
      rd(fir_eq_pkg::IDX_TAP6, 32'h0000_FFFF);
      wr(fir_eq_pkg::IDX_CENTER, 32'hFFFF_FFFF);
      rd(fir_eq_pkg::IDX_CENTER, 32'h00FF_FFFF);
      rd(12'h421, 32'h0000_0000, fir_eq_pkg::RESP_SLVERR);
      wr(12'h421, 32'h0000_0001, fir_eq_pkg::RESP_SLVERR);
   endtask : field_widths
   task automatic impulse();
      logic [15:0] e[9] = '{0, 0, 0, 16'h0064, 16'h0064, 16'hFF9C, 0, 0, 0};
      wr(fir_eq_pkg::IDX_TAP4, 32'h0000_0400);
      wr(fir_eq_pkg::IDX_CENTER, 32'h0001_0000);
      wr(fir_eq_pkg::IDX_TAP6, 32'h0000_0C00);
      wr(fir_eq_pkg::IDX_CFG, 32'h0000_003A);
      chk({merge, weight}, 32'h0000_000E);
      got.delete();
      push(1, 12'h064, 12'h000);
      push(8, 12'h000, 12'h000);
      drain(9);
      foreach (e[j]) chk(got[j], e[j]);
   endtask : impulse
   task automatic bypass();
      logic [1:0] m[3] = '{2'h0, 2'h1, 2'h3};
      foreach (m[j]) begin
         wr(fir_eq_pkg::IDX_CFG, {30'h0, m[j]});
         got.delete();
         push(1, 12'h805, 12'h000);
         drain(1);
         chk(got[0], 16'hF805);
      end
   endtask : bypass
   task automatic fill();
      stall <= 1;
      got.delete();
      push(17, 12'h001, 12'h001);
      @(posedge aclk);
      chk(ird, 0);
      {stall, link} <= 2'b01;
      drain(17);
      foreach (got[j]) chk(got[j], j + 1);
      rd(fir_eq_pkg::IDX_STATUS, 32'h0000_0100);
   endtask : fill
   initial begin
      repeat (20) @(posedge aclk);
      aresetn <= 1;
      reset_values();
      field_widths();
      impulse();
      bypass();
      fill();
      test_done();
   end
endmodule : fir_equalizer_coeff_taps_tb
`default_nettype wire
